// file: verilog/stp_pkg.sv
// stepper step translator: register map, field layout, reset values, mode codes
// assumes a 32-bit apb register bus and a 7-bit translator position
package stp_pkg;

  // register byte offsets
  localparam logic [7:0] STP_OFF_CTRL   = 8'h00;
  localparam logic [7:0] STP_OFF_STATUS = 8'h04;
  localparam logic [7:0] STP_OFF_COIL   = 8'h08;

  // widths
  localparam int unsigned STP_POS_W  = 7;
  localparam int unsigned STP_MODE_W = 3;
  localparam int unsigned STP_CUR_W  = 11;

  // control register fields
  localparam int unsigned STP_CTRL_RES_LSB  = 0;
  localparam int unsigned STP_CTRL_DINV_BIT = 3;
  localparam int unsigned STP_CTRL_RUN_BIT  = 4;
  localparam int unsigned STP_CTRL_STEP_BIT = 5;

  // status register fields
  localparam int unsigned STP_ST_POS_LSB   = 0;
  localparam int unsigned STP_ST_MODE_LSB  = 8;
  localparam int unsigned STP_ST_DIR_BIT   = 12;
  localparam int unsigned STP_ST_RUN_BIT   = 13;
  localparam int unsigned STP_ST_PINA_BIT  = 16;
  localparam int unsigned STP_ST_PINB_BIT  = 17;
  localparam int unsigned STP_ST_PDIR_BIT  = 18;
  localparam int unsigned STP_ST_PRUN_BIT  = 19;
  localparam int unsigned STP_ST_PSTEP_BIT = 20;

  // coil register fields
  localparam int unsigned STP_COIL_X_LSB = 0;
  localparam int unsigned STP_COIL_Y_LSB = 16;

  // reset values
  localparam logic [STP_POS_W-1:0]  STP_POS_RST  = 7'h10;
  localparam logic [STP_MODE_W-1:0] STP_MODE_RST = 3'h0;
  localparam logic signed [STP_CUR_W-1:0] STP_CUR_RST = 11'sh2C3;

  // effective step-mode codes
  localparam logic [STP_MODE_W-1:0] STP_MODE_HALF  = 3'h4;
  localparam logic [STP_MODE_W-1:0] STP_MODE_FULL2 = 3'h7;
  localparam logic [STP_POS_W-1:0]  STP_FULL2_OFS  = 7'h10;
  localparam logic [2:0]            STP_FULL_SHIFT = 3'h5;

  // coil current in tenths of a percent of peak
  localparam logic signed [STP_CUR_W-1:0] STP_CUR_FULL2 = 11'sh2C6;

  typedef enum logic {
    STP_APB_WAIT = 1'b0,
    STP_APB_DONE = 1'b1
  } stp_apb_e;

endpackage

// file: verilog/stp_coil_table.sv
// stepper step translator: sine/cosine coil set-point lookup
// purely combinational; the caller registers the results
`timescale 1ns/1ps

module stp_coil_table (
  // position and mode
  input  wire logic [stp_pkg::STP_POS_W-1:0]         pos,
  input  wire logic [stp_pkg::STP_MODE_W-1:0]        mode,
  // set-points in tenths of a percent of peak
  output logic signed [stp_pkg::STP_CUR_W-1:0]       coil_x,
  output logic signed [stp_pkg::STP_CUR_W-1:0]       coil_y
);

  // quarter wave, 33 points, index 0..32
  function automatic logic [stp_pkg::STP_CUR_W-1:0] stp_quarter(input logic [5:0] r);
    logic [stp_pkg::STP_CUR_W-1:0] v;
    v = 11'h000;
    unique case (r)
      6'h00: v = 11'h000;  6'h01: v = 11'h031;  6'h02: v = 11'h062;
      6'h03: v = 11'h093;  6'h04: v = 11'h0C3;  6'h05: v = 11'h0F3;
      6'h06: v = 11'h122;  6'h07: v = 11'h151;  6'h08: v = 11'h17F;
      6'h09: v = 11'h1AC;  6'h0A: v = 11'h1D7;  6'h0B: v = 11'h202;
      6'h0C: v = 11'h22C;  6'h0D: v = 11'h254;  6'h0E: v = 11'h27A;
      6'h0F: v = 11'h2A0;  6'h10: v = 11'h2C3;  6'h11: v = 11'h2E5;
      6'h12: v = 11'h305;  6'h13: v = 11'h323;  6'h14: v = 11'h33F;
      6'h15: v = 11'h35A;  6'h16: v = 11'h372;  6'h17: v = 11'h388;
      6'h18: v = 11'h39C;  6'h19: v = 11'h3AE;  6'h1A: v = 11'h3BD;
      6'h1B: v = 11'h3CA;  6'h1C: v = 11'h3D5;  6'h1D: v = 11'h3DD;
      6'h1E: v = 11'h3E3;  6'h1F: v = 11'h3E7;  6'h20: v = 11'h3E8;
      default: v = 11'h000;
    endcase
    return v;
  endfunction

  // full sine over 128 positions from the quarter wave
  function automatic logic signed [stp_pkg::STP_CUR_W-1:0] stp_sine(
      input logic [stp_pkg::STP_POS_W-1:0] p);
    logic [5:0]                    r;
    logic [stp_pkg::STP_CUR_W-1:0] m;
    r = {1'b0, p[4:0]};
    if (p[5]) begin
      r = 6'h20 - r;
    end
    m = stp_quarter(r);
    return p[6] ? -$signed(m) : $signed(m);
  endfunction

  logic [stp_pkg::STP_POS_W-1:0] cos_pos;
  logic signed [stp_pkg::STP_CUR_W-1:0] sx;
  logic signed [stp_pkg::STP_CUR_W-1:0] sy;

  always_comb begin
    cos_pos = pos + 7'h20;
    sx      = stp_sine(cos_pos);
    sy      = stp_sine(pos);
    coil_x  = sx;
    coil_y  = sy;
    // two-coil full step drives the square corner, not the circle
    if (mode == stp_pkg::STP_MODE_FULL2) begin
      coil_x = sx[stp_pkg::STP_CUR_W-1] ? -stp_pkg::STP_CUR_FULL2 : stp_pkg::STP_CUR_FULL2;
      coil_y = sy[stp_pkg::STP_CUR_W-1] ? -stp_pkg::STP_CUR_FULL2 : stp_pkg::STP_CUR_FULL2;
    end
  end

endmodule // stp_coil_table

// file: verilog/stp_translator.sv
// stepper step translator: position keeper, mode resolution, apb register slave
// assumes all pins synchronous to pclk; coil set-points feed external regulators
//
// Contract
// - steps become coil set-points under mode, direction, run; run here only drives run_hold_active, not steps or set-points
// - effective mode is field plus pin value
// - codes 000..100 select 1/32 to 1/2 step
// - reset gives 1/32 mode at position 16
// - default mode steps position by one
// - coarser mode clears unused low position bits
// - misaligned position snaps toward rotation direction
// - finer mode keeps position, low bits zero
// - mode changes wait for a step trigger
// - trigger applies mode present at that moment
// - coil currents follow sine/cosine table
// - direction is pin xor invert bit
// - trigger is pin rising edge or soft bit
// - codes 101/110 one-coil, 111 two-coil full step
// - position readable, updated right after trigger
//
// The implementer's own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps

module stp_translator #(
  parameter int unsigned ADDR_W = 8
) (
  // clock and reset
  input  wire logic                                 pclk,
  input  wire logic                                 presetn,
  // apb slave
  input  wire logic                                 psel,
  input  wire logic                                 penable,
  input  wire logic                                 pwrite,
  input  wire logic [ADDR_W-1:0]                    paddr,
  input  wire logic [31:0]                          pwdata,
  input  wire logic [3:0]                           pstrb,
  output logic [31:0]                               prdata,
  output logic                                      pready,
  output logic                                      pslverr,
  // motion pins
  input  wire logic                                 step_advance_pin,
  input  wire logic                                 direction_pin,
  input  wire logic                                 run_hold_pin,
  input  wire logic                                 resolution_offset_pin_a,
  input  wire logic                                 resolution_offset_pin_b,
  // translator outputs
  output logic [stp_pkg::STP_POS_W-1:0]             translator_position,
  output logic [stp_pkg::STP_MODE_W-1:0]            active_mode,
  output logic                                      run_hold_active,
  output logic signed [stp_pkg::STP_CUR_W-1:0]      coil_x_setpoint,
  output logic signed [stp_pkg::STP_CUR_W-1:0]      coil_y_setpoint
);

  // the decoder reads address bits 7..2, so narrower buses cannot be served
  if (ADDR_W < 8 || ADDR_W > 32) begin : g_addr_w_check
    $error("stp_translator: ADDR_W must be 8..32");
  end

  typedef struct packed {
    logic [stp_pkg::STP_POS_W-1:0]        pos;
    logic [stp_pkg::STP_MODE_W-1:0]       res_field;
    logic [stp_pkg::STP_MODE_W-1:0]       mode;
    logic                                 dir_inv;
    logic                                 run_soft;
    logic                                 soft_step;
    logic                                 pin_prev;
    logic                                 run_act;
    stp_pkg::stp_apb_e                    phase;
    logic [31:0]                          rdata;
    logic                                 err;
    logic signed [stp_pkg::STP_CUR_W-1:0] cx;
    logic signed [stp_pkg::STP_CUR_W-1:0] cy;
  } stp_state_s;

  // field plus pin offset, held at the top code rather than wrapping back to 1/32
  function automatic logic [stp_pkg::STP_MODE_W-1:0] stp_eff_mode(
      input logic [stp_pkg::STP_MODE_W-1:0] field,
      input logic                           pin_b,
      input logic                           pin_a);
    logic [stp_pkg::STP_MODE_W:0] sum;
    sum = {1'b0, field} + {2'b00, pin_b, pin_a};
    if (sum[stp_pkg::STP_MODE_W]) begin
      sum = {1'b0, stp_pkg::STP_MODE_FULL2};
    end
    return sum[stp_pkg::STP_MODE_W-1:0];
  endfunction

  // next position for one trigger in the given mode and direction
  function automatic logic [stp_pkg::STP_POS_W-1:0] stp_next_pos(
      input logic [stp_pkg::STP_POS_W-1:0]  p,
      input logic [stp_pkg::STP_MODE_W-1:0] m,
      input logic                           up);
    logic [2:0]                    shift;
    logic [stp_pkg::STP_POS_W-1:0] ofs;
    logic [stp_pkg::STP_POS_W-1:0] stp;
    logic [stp_pkg::STP_POS_W-1:0] mask;
    logic [stp_pkg::STP_POS_W-1:0] rel;
    logic [stp_pkg::STP_POS_W-1:0] base;
    logic [stp_pkg::STP_POS_W-1:0] nrel;
    shift = (m > stp_pkg::STP_MODE_HALF) ? stp_pkg::STP_FULL_SHIFT : m;
    ofs   = (m == stp_pkg::STP_MODE_FULL2) ? stp_pkg::STP_FULL2_OFS : 7'h00;
    stp   = 7'h01 << shift;
    mask  = stp - 7'h01;
    rel   = p - ofs;
    base  = rel & ~mask;
    if ((rel & mask) == 7'h00) begin
      // aligned: finer modes land here too, their new low bits being zero
      nrel = up ? (rel + stp) : (rel - stp);
    end else begin
      nrel = up ? (base + stp) : base;
    end
    return nrel + ofs;
  endfunction

  stp_state_s s_q;
  stp_state_s s_d;

  logic [stp_pkg::STP_MODE_W-1:0]       eff_mode;
  logic                                 eff_dir;
  logic                                 pin_edge;
  logic                                 trigger;
  logic                                 soft_served;
  logic                                 access;
  logic [7:0]                           word_addr;
  logic                                 hit_ctrl;
  logic                                 hit_status;
  logic                                 hit_coil;
  logic [31:0]                          status_word;
  logic [31:0]                          coil_word;
  logic [31:0]                          ctrl_word;
  logic signed [stp_pkg::STP_CUR_W-1:0] tab_x;
  logic signed [stp_pkg::STP_CUR_W-1:0] tab_y;

  stp_coil_table u_table (
    .pos    (s_q.pos),
    .mode   (s_q.mode),
    .coil_x (tab_x),
    .coil_y (tab_y)
  );

  always_comb begin
    s_d = s_q;

    // step resolution and direction as seen at this very cycle
    eff_mode = stp_eff_mode(s_q.res_field, resolution_offset_pin_b,
                            resolution_offset_pin_a);
    eff_dir  = direction_pin ^ s_q.dir_inv;

    // a pin edge and a pending soft step in one cycle: the pin goes first,
    // the soft request stays pending and is served next cycle, so both count
    pin_edge    = step_advance_pin & ~s_q.pin_prev;
    trigger     = pin_edge | s_q.soft_step;
    soft_served = s_q.soft_step & ~pin_edge;
    s_d.pin_prev = step_advance_pin;

    // only a trigger moves the position or latches a new mode
    if (trigger) begin
      s_d.pos  = stp_next_pos(s_q.pos, eff_mode, eff_dir);
      s_d.mode = eff_mode;
    end
    if (soft_served) begin
      s_d.soft_step = 1'b0;
    end

    s_d.run_act = run_hold_pin ^ s_q.run_soft;

    // set-points follow the table one cycle behind the position
    s_d.cx = tab_x;
    s_d.cy = tab_y;

    // register read images
    ctrl_word = 32'h0000_0000;
    ctrl_word[stp_pkg::STP_CTRL_RES_LSB +: stp_pkg::STP_MODE_W] = s_q.res_field;
    ctrl_word[stp_pkg::STP_CTRL_DINV_BIT] = s_q.dir_inv;
    ctrl_word[stp_pkg::STP_CTRL_RUN_BIT]  = s_q.run_soft;
    ctrl_word[stp_pkg::STP_CTRL_STEP_BIT] = s_q.soft_step;

    status_word = 32'h0000_0000;
    status_word[stp_pkg::STP_ST_POS_LSB +: stp_pkg::STP_POS_W]   = s_q.pos;
    status_word[stp_pkg::STP_ST_MODE_LSB +: stp_pkg::STP_MODE_W] = s_q.mode;
    status_word[stp_pkg::STP_ST_DIR_BIT]   = eff_dir;
    status_word[stp_pkg::STP_ST_RUN_BIT]   = s_q.run_act;
    status_word[stp_pkg::STP_ST_PINA_BIT]  = resolution_offset_pin_a;
    status_word[stp_pkg::STP_ST_PINB_BIT]  = resolution_offset_pin_b;
    status_word[stp_pkg::STP_ST_PDIR_BIT]  = direction_pin;
    status_word[stp_pkg::STP_ST_PRUN_BIT]  = run_hold_pin;
    status_word[stp_pkg::STP_ST_PSTEP_BIT] = step_advance_pin;

    coil_word = 32'h0000_0000;
    coil_word[stp_pkg::STP_COIL_X_LSB +: stp_pkg::STP_CUR_W] = s_q.cx;
    coil_word[stp_pkg::STP_COIL_Y_LSB +: stp_pkg::STP_CUR_W] = s_q.cy;

    // apb: one wait state so read data and error leave straight from flops
    word_addr = 8'h00;
    word_addr[7:2] = paddr[7:2];
    hit_ctrl   = (word_addr == stp_pkg::STP_OFF_CTRL);
    hit_status = (word_addr == stp_pkg::STP_OFF_STATUS);
    hit_coil   = (word_addr == stp_pkg::STP_OFF_COIL);
    // a shift instead of a part-select keeps the default width free of an empty range
    if ((paddr >> 8) != '0) begin
      hit_ctrl   = 1'b0;
      hit_status = 1'b0;
      hit_coil   = 1'b0;
    end
    access = psel & penable;

    unique case (s_q.phase)
      stp_pkg::STP_APB_WAIT: begin
        if (access) begin
          s_d.phase = stp_pkg::STP_APB_DONE;
          s_d.err   = ~(hit_ctrl | hit_status | hit_coil);
          s_d.rdata = 32'h0000_0000;
          if (!pwrite) begin
            if (hit_ctrl) begin
              s_d.rdata = ctrl_word;
            end else if (hit_status) begin
              s_d.rdata = status_word;
            end else if (hit_coil) begin
              s_d.rdata = coil_word;
            end
          end
        end
      end
      stp_pkg::STP_APB_DONE: begin
        s_d.phase = stp_pkg::STP_APB_WAIT;
        s_d.err   = 1'b0;
        // the write lands on the edge where the master sees pready high
        if (access && pwrite && hit_ctrl && pstrb[0]) begin
          s_d.res_field = pwdata[stp_pkg::STP_CTRL_RES_LSB +: stp_pkg::STP_MODE_W];
          s_d.dir_inv   = pwdata[stp_pkg::STP_CTRL_DINV_BIT];
          s_d.run_soft  = pwdata[stp_pkg::STP_CTRL_RUN_BIT];
          // writing one requests a step; a zero never cancels a pending one
          if (pwdata[stp_pkg::STP_CTRL_STEP_BIT]) begin
            s_d.soft_step = 1'b1;
          end
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q.pos       <= stp_pkg::STP_POS_RST;
      s_q.res_field <= stp_pkg::STP_MODE_RST;
      s_q.mode      <= stp_pkg::STP_MODE_RST;
      s_q.dir_inv   <= 1'b0;
      s_q.run_soft  <= 1'b0;
      s_q.soft_step <= 1'b0;
      s_q.pin_prev  <= 1'b1;
      s_q.run_act   <= 1'b0;
      s_q.phase     <= stp_pkg::STP_APB_WAIT;
      s_q.rdata     <= 32'h0000_0000;
      s_q.err       <= 1'b0;
      s_q.cx        <= stp_pkg::STP_CUR_RST;
      s_q.cy        <= stp_pkg::STP_CUR_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata              = s_q.rdata;
  assign pready              = (s_q.phase == stp_pkg::STP_APB_DONE);
  assign pslverr             = s_q.err;
  assign translator_position = s_q.pos;
  assign active_mode         = s_q.mode;
  assign run_hold_active     = s_q.run_act;
  assign coil_x_setpoint     = s_q.cx;
  assign coil_y_setpoint     = s_q.cy;

endmodule // stp_translator

// file: dv/stp_translator_checker.sv
// checker for the step translator: step triggers, mode latch, grid, coil values, apb timing
// bound to every stp_translator; sees only its ports, all in the pclk domain
`timescale 1ns/1ps
module stp_translator_checker #(
  parameter int unsigned ADDR_W = 8
) (
  input wire logic                                 pclk,
  input wire logic                                 presetn,
  input wire logic                                 psel,
  input wire logic                                 penable,
  input wire logic [ADDR_W-1:0]                    paddr,
  input wire logic                                 pready,
  input wire logic                                 pslverr,
  input wire logic                                 step_advance_pin,
  input wire logic [stp_pkg::STP_POS_W-1:0]        translator_position,
  input wire logic [stp_pkg::STP_MODE_W-1:0]       active_mode,
  input wire logic signed [stp_pkg::STP_CUR_W-1:0] coil_x_setpoint,
  input wire logic signed [stp_pkg::STP_CUR_W-1:0] coil_y_setpoint
);
  logic pin_q;
  logic trig;

  default clocking dc @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // same edge detector as the block: a pin already high at release is no step
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) pin_q <= 1'b1;
    else pin_q <= step_advance_pin;
  end
  assign trig = step_advance_pin & ~pin_q;

  function automatic logic al_ok(logic [6:0] p, logic [2:0] m);
    case (m)
      3'h7:       return p[4:0] == 5'h10;
      3'h5, 3'h6: return p[4:0] == 5'h00;
      default:    return (p & ((7'h01 << m) - 7'h01)) == 7'h00;
    endcase
  endfunction

  // a soft step lands two cycles after its write, hence the psel history
  a_hold_still: assert property (!trig && !$past(psel) && !$past(psel, 2) |=>
    $stable(translator_position)) else $error("position moved without a trigger");
  a_mode_hold: assert property (!trig && !$past(psel) && !$past(psel, 2) |=>
    $stable(active_mode)) else $error("mode changed without a trigger");
  a_step_fine: assert property (trig |=> active_mode != 3'h0 ||
    translator_position - $past(translator_position) == 7'h01 ||
    $past(translator_position) - translator_position == 7'h01)
    else $error("fine mode step was not one position");
  a_grid_align: assert property (al_ok(translator_position, active_mode))
    else $error("position off the grid of the active mode");
  a_coil_zero: assert property ($past(translator_position) == 7'h00 &&
    $past(active_mode) != 3'h7 |-> coil_x_setpoint == 11'sh3E8 && coil_y_setpoint == 11'sh000)
    else $error("coil values wrong at position zero");
  a_coil_diag: assert property ($past(translator_position) == 7'h10 &&
    $past(active_mode) != 3'h7 |-> coil_x_setpoint == 11'sh2C3 && coil_y_setpoint == 11'sh2C3)
    else $error("coil values wrong at the equal current point");
  a_ready_wait: assert property (psel && penable && !pready |=> pready ##1 !pready)
    else $error("ready not a single pulse after one wait state");
  a_err_unmapped: assert property (pready |-> pslverr == ((paddr >> 2) > 2))
    else $error("error response does not match the address");

  c_full2: cover property (trig ##1 active_mode == 3'h7);
  c_wrap: cover property (translator_position == 7'h7F && $past(translator_position) == 7'h00);
  c_unmapped: cover property (pready && pslverr);
endmodule // stp_translator_checker

bind stp_translator stp_translator_checker #(.ADDR_W(ADDR_W)) u_chk (
  .pclk, .presetn, .psel, .penable, .paddr, .pready, .pslverr, .step_advance_pin,
  .translator_position, .active_mode, .coil_x_setpoint, .coil_y_setpoint
);

// file: dv/stp_mcu_pins.sv
// controller-side pin model: one step pulse on the step pin per request
// pulse widths are scaled down to HOLD pclk cycles high, then at least HOLD low
`timescale 1ns/1ps
module stp_mcu_pins #(
  parameter int HOLD = 3
) (
  input  wire logic pclk,
  input  wire logic req,
  output logic      step_advance_pin,
  output logic      busy
);
  int cnt = 0;

  initial step_advance_pin = 1'b0;
  always @(posedge pclk) begin
    if (cnt > 0) cnt <= cnt - 1;
    else if (req) cnt <= 2 * HOLD;
    step_advance_pin <= cnt > HOLD;
  end
  // busy covers the low time too, so direction and mode pins may change after it
  assign busy = cnt != 0;
endmodule // stp_mcu_pins

// file: dv/tb_stepper_step_translator.sv
// testbench for the step translator: apb master, pin stimulus, integer position model
// waits for the apb slave's pready through any number of wait states; assumes a 125 MHz pclk
`timescale 1ns/1ps
module tb_stepper_step_translator;
  logic              pclk, presetn, psel, penable, pwrite, req, busy, pslverr, pready, rerr;
  logic [7:0]        paddr;
  logic [31:0]       pwdata, prdata, rdat;
  logic [3:0]        pstrb;
  logic              step_advance_pin, direction_pin, run_hold_pin, run_hold_active;
  logic              resolution_offset_pin_a, resolution_offset_pin_b;
  logic [6:0]        translator_position;
  logic [2:0]        active_mode;
  logic signed [10:0] coil_x_setpoint, coil_y_setpoint;
  int                error_cnt, samples_checked, pos, mode, fld;
  bit                dp, dinv, pa, pb, rb, rp;

  stp_translator #(.ADDR_W(8)) u_dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
    .pslverr, .step_advance_pin, .direction_pin, .run_hold_pin, .resolution_offset_pin_a,
    .resolution_offset_pin_b, .translator_position, .active_mode, .run_hold_active,
    .coil_x_setpoint, .coil_y_setpoint
  );
  stp_mcu_pins #(.HOLD(3)) u_mcu (.pclk, .req, .step_advance_pin, .busy);

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  task automatic results();
    $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // called just after an edge; ends one edge after release so strobes never toggle twice
  task automatic apb(input bit w, input logic [7:0] a, input logic [31:0] d);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no limit of its own: a slave that never answers is caught by the watchdog
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  function automatic int nxt(int p, int m, bit up);
    int s, o, r;
    s = (m >= 5) ? 32 : (1 << m);
    o = (m == 7) ? 16 : 0;
    r = (p - o) & 127;
    if (r % s == 0) r = up ? r + s : r - s;
    else r = up ? (r / s + 1) * s : (r / s) * s;
    return (r + o) & 127;
  endfunction

  function automatic logic [31:0] coil(int p, int m);
    int x, y;
    x = int'(1000.0 * $cos(6.2831853072 * p / 128));
    y = int'(1000.0 * $sin(6.2831853072 * p / 128));
    if (m == 7) begin
      x = x > 0 ? 710 : -710;
      y = y > 0 ? 710 : -710;
    end
    return {5'h00, y[10:0], 5'h00, x[10:0]};
  endfunction

  task automatic check_state();
    apb(1'b0, 8'h04, 32'h0);
    chk("position", pos, rdat[6:0]);
    chk("mode", mode, rdat[10:8]);
    apb(1'b0, 8'h08, 32'h0);
    chk("coil", coil(pos, mode), rdat & 32'h07FF07FF);
    chk("position pin", pos, translator_position);
    chk("mode pin", mode, active_mode);
    chk("coils", coil(pos, mode), {5'h00, coil_y_setpoint, 5'h00, coil_x_setpoint});
  endtask

  task automatic step();
    req <= 1'b1;
    @(posedge pclk);
    req <= 1'b0;
    @(posedge pclk);
    while (busy) @(posedge pclk);
  endtask

  initial begin
    repeat (30000) @(posedge pclk);
    error_cnt++;
    results();
  end

  initial begin
    void'($urandom(28));
    {presetn, psel, penable, pwrite, req, direction_pin, run_hold_pin} = 7'h00;
    {resolution_offset_pin_a, resolution_offset_pin_b, paddr, pwdata} = 42'h0;
    pstrb = 4'hF;
    pos = 16;
    mode = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    check_state();
    $display("test reset done");
    // first twenty: fine mode, downwards through zero, both direction encodings
    for (int i = 0; i < 100; i++) begin
      fld = (i < 20) ? 0 : i % 8;
      dinv = (i < 20) ? (i >= 10) : 1'($urandom);
      dp = (i < 20) ? dinv : 1'($urandom);
      {pb, pa} = (i >= 20 && i % 3 == 0) ? 2'($urandom) : 2'h0;
      rb = 1'($urandom);
      rp = 1'($urandom);
      direction_pin <= dp;
      resolution_offset_pin_a <= pa;
      resolution_offset_pin_b <= pb;
      run_hold_pin <= rp;
      apb(1'b1, 8'h00, {27'h0, rb, dinv, fld[2:0]});
      check_state();
      mode = fld + 2 * pb + pa;
      if (mode > 7) mode = 7;
      step();
      pos = nxt(pos, mode, dp ^ dinv);
      check_state();
      chk("run_hold", rp ^ rb, run_hold_active);
    end
    $display("test step sweep done");
    direction_pin <= 1'b0;
    resolution_offset_pin_a <= 1'b0;
    resolution_offset_pin_b <= 1'b0;
    apb(1'b1, 8'h00, 32'h00000028);
    mode = 0;
    pos = nxt(pos, 0, 1'b1);
    check_state();
    apb(1'b0, 8'h00, 32'h0);
    chk("ctrl", 32'h00000008, rdat);
    // byte 0 strobe low: the write, soft step included, must be dropped
    pstrb <= 4'hE;
    apb(1'b1, 8'h00, 32'h00000027);
    pstrb <= 4'hF;
    apb(1'b0, 8'h00, 32'h0);
    chk("ctrl masked", 32'h00000008, rdat);
    $display("test soft step done");
    apb(1'b1, 8'h04, 32'hFFFFFFFF);
    check_state();
    apb(1'b0, 8'h0C, 32'h0);
    chk("slverr", 32'h1, rerr);
    chk("rdata", 32'h0, rdat);
    $display("test access done");
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    pos = 16;
    mode = 0;
    check_state();
    $display("test second reset done");
    results();
  end
endmodule // tb_stepper_step_translator
